// file: bcce_pkg.sv
package bcce_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR  = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_WORKING       = 8'h08;
  localparam logic [7:0] ADDR_PC            = 8'h0C;
  localparam logic [7:0] ADDR_PC_HIGH_LATCH = 8'h10;
  localparam logic [7:0] ADDR_STACK_TOP     = 8'h14;
  localparam logic [7:0] ADDR_FADDR  = 8'h18;
  localparam logic [7:0] ADDR_FDATA  = 8'h1C;

  // ------------------------------------------------------------
  // Status field positions and reset values
  // ------------------------------------------------------------
  localparam int ST_Z_BIT    = 0;
  localparam int ST_TO_BIT   = 1;
  localparam int ST_POWER_DOWN_BIT = 2;
  localparam int ST_SKIP_BIT = 3;
  localparam int ST_BUSY_BIT = 4;
  localparam logic        RST_TO     = 1'b1;
  localparam logic        RST_POWER_DOWN = 1'b1;
  localparam logic [15:0] RST_PC     = 16'h0000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;

  // ------------------------------------------------------------
  // Opcode patterns
  // ------------------------------------------------------------
  localparam logic [4:0]  PAT_BIT_TEST_SKIP      = 5'h12;
  localparam logic [4:0]  PAT_BIT_TOGGLE         = 5'h07;
  localparam logic [2:0]  PAT_CALL               = 3'h7;
  localparam logic [6:0]  PAT_CLEAR_FILE         = 7'h14;
  localparam logic [15:0] PAT_WATCHDOG_CLEAR     = 16'h0004;
  localparam logic [6:0]  PAT_COMPLEMENT_FILE    = 7'h09;
  localparam logic [7:0]  PAT_COMPARE_EQUAL_SKIP = 8'h31;

  typedef enum logic [3:0] {
    OP_NOP, OP_HOLD, OP_BIT_TEST_SKIP, OP_BIT_TOGGLE, OP_CALL, OP_CLEAR_FILE, OP_WATCHDOG_CLEAR,
    OP_COMPLEMENT_FILE, OP_COMPARE_EQUAL_SKIP
  } bcce_op_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_Q1   = 5'b00010,
    ST_Q2   = 5'b00100,
    ST_Q3   = 5'b01000,
    ST_Q4   = 5'b10000
  } bcce_state_t;

  typedef struct packed {
    bcce_op_t    op;
    logic [7:0]  faddr;
    logic [2:0]  bsel;
    logic        dsel;
    logic [12:0] lit;
  } bcce_exec_t;

endpackage

// file: bcce_core.sv
`timescale 1ns/10ps
module bcce_core
  import bcce_pkg::*;
#(
  parameter int STACK_DEPTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             watchdog_clear
);

  localparam int SPW = $clog2(STACK_DEPTH);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  bcce_state_t    state_reg,   state_next;
  bcce_exec_t     ex_reg,      ex_next;
  logic [15:0]    instr_reg,   instr_next;
  logic           call2_reg,   call2_next;
  logic           skip_reg,    skip_next;
  logic [7:0]     operand_reg, operand_next;
  logic [7:0]     result_reg,  result_next;
  logic [7:0]     working_register_reg, working_register_next;
  logic [15:0]    pc_reg,      pc_next;
  logic [7:0]     program_counter_high_latch_reg, program_counter_high_latch_next;
  logic           z_reg,       z_next;
  logic           timeout_status_bit_reg, timeout_status_bit_next;
  logic           power_down_status_bit_reg, power_down_status_bit_next;
  logic [SPW-1:0] sp_reg,      sp_next;
  logic [7:0]     faddr_reg,   faddr_next;
  logic [31:0]    prdata_reg,  prdata_next;
  logic           pready_reg,  pready_next;
  logic           pslverr_reg, pslverr_next;
  logic           watchdog_clear_reg, watchdog_clear_next;

  logic [7:0]     dmem [256];
  logic [15:0]    stack [STACK_DEPTH];
  logic           mem_we;
  logic [7:0]     mem_addr;
  logic [7:0]     mem_wd;
  logic           push;
  logic           busy;
  logic           setup;
  logic           wr_ok;
  logic [15:0]    stack_top;
  logic [7:0]     diff;

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign watchdog_clear = watchdog_clear_reg;

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic bcce_op_t decode_op(input logic [15:0] ins);
    bcce_op_t op;
    op = OP_NOP;
    if (ins[15:13] == PAT_CALL) begin
      op = OP_CALL;
    end else if (ins[15:11] == PAT_BIT_TEST_SKIP) begin
      op = OP_BIT_TEST_SKIP;
    end else if (ins[15:11] == PAT_BIT_TOGGLE) begin
      op = OP_BIT_TOGGLE;
    end else if (ins[15:9] == PAT_CLEAR_FILE) begin
      op = OP_CLEAR_FILE;
    end else if (ins == PAT_WATCHDOG_CLEAR) begin
      op = OP_WATCHDOG_CLEAR;
    end else if (ins[15:9] == PAT_COMPLEMENT_FILE) begin
      op = OP_COMPLEMENT_FILE;
    end else if (ins[15:8] == PAT_COMPARE_EQUAL_SKIP) begin
      op = OP_COMPARE_EQUAL_SKIP;
    end
    return op;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == ADDR_INSTR) || (a == ADDR_STATUS) || (a == ADDR_WORKING) || (a == ADDR_PC) ||
           (a == ADDR_PC_HIGH_LATCH) || (a == ADDR_STACK_TOP) || (a == ADDR_FADDR) || (a == ADDR_FDATA);
  endfunction

  assign busy  = (state_reg != ST_IDLE);
  assign setup = psel && !penable;
  // Writes refused at setup are dropped at access
  assign wr_ok = psel && penable && pwrite && pready_reg && !pslverr_reg;
  assign stack_top = stack[sp_reg - SPW'(1)];
  assign diff  = operand_reg - working_register_reg;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    ex_next      = ex_reg;
    instr_next   = instr_reg;
    call2_next   = call2_reg;
    skip_next    = skip_reg;
    operand_next = operand_reg;
    result_next  = result_reg;
    working_register_next = working_register_reg;
    pc_next      = pc_reg;
    program_counter_high_latch_next = program_counter_high_latch_reg;
    z_next       = z_reg;
    timeout_status_bit_next    = timeout_status_bit_reg;
    power_down_status_bit_next = power_down_status_bit_reg;
    sp_next      = sp_reg;
    faddr_next   = faddr_reg;
    watchdog_clear_next = 1'b0;
    mem_we       = 1'b0;
    mem_addr     = faddr_reg;
    mem_wd       = pwdata[7:0];
    push         = 1'b0;

    case (state_reg)
      ST_IDLE: begin
        if (wr_ok && paddr == ADDR_INSTR) begin
          instr_next = pwdata[15:0];
          state_next = ST_Q1;
        end
      end
      ST_Q1: begin
        ex_next.faddr = instr_reg[7:0];
        ex_next.bsel  = instr_reg[10:8];
        ex_next.dsel  = instr_reg[8];
        ex_next.lit   = instr_reg[12:0];
        if (call2_reg) begin
          ex_next.op = OP_HOLD;
          call2_next = 1'b0;
        end else if (skip_reg) begin
          ex_next.op = OP_NOP;
          skip_next  = 1'b0;
        end else begin
          ex_next.op = decode_op(instr_reg);
        end
        state_next = ST_Q2;
      end
      ST_Q2: begin
        operand_next = dmem[ex_reg.faddr];
        if (ex_reg.op == OP_CALL) begin
          push    = 1'b1;
          sp_next = sp_reg + SPW'(1);
        end
        state_next = ST_Q3;
      end
      ST_Q3: begin
        result_next = operand_reg;
        case (ex_reg.op)
          OP_BIT_TEST_SKIP:      skip_next   = operand_reg[ex_reg.bsel];
          OP_BIT_TOGGLE:         result_next = operand_reg ^ (8'h01 << ex_reg.bsel);
          OP_CLEAR_FILE:         result_next = 8'h00;
          OP_COMPLEMENT_FILE:    result_next = ~operand_reg;
          OP_COMPARE_EQUAL_SKIP: skip_next   = (diff == 8'h00);
          default:   result_next = operand_reg;
        endcase
        state_next = ST_Q4;
      end
      ST_Q4: begin
        mem_addr   = ex_reg.faddr;
        mem_wd     = result_reg;
        state_next = ST_IDLE;
        if (ex_reg.op != OP_HOLD && ex_reg.op != OP_CALL) begin
          pc_next = pc_reg + 16'h0001;
        end
        case (ex_reg.op)
          OP_BIT_TOGGLE: mem_we = 1'b1;
          OP_CLEAR_FILE: begin
            mem_we = 1'b1;
            if (!ex_reg.dsel) begin
              working_register_next = 8'h00;
            end
          end
          OP_COMPLEMENT_FILE: begin
            z_next = (result_reg == 8'h00);
            if (ex_reg.dsel) begin
              mem_we = 1'b1;
            end else begin
              working_register_next = result_reg;
            end
          end
          OP_WATCHDOG_CLEAR: begin
            watchdog_clear_next = 1'b1;
            timeout_status_bit_next    = 1'b1;
            power_down_status_bit_next = 1'b1;
          end
          OP_CALL: begin
            // Top bits kept: no reach outside the page
            pc_next = {pc_reg[15:13], ex_reg.lit};
            program_counter_high_latch_next = {pc_reg[15:13], ex_reg.lit[12:8]};
            call2_next = 1'b1;
            state_next = ST_Q1;
          end
          default: mem_we = 1'b0;
        endcase
      end
      default: state_next = ST_IDLE;
    endcase

    if (wr_ok && !busy) begin
      if (paddr == ADDR_STATUS) begin
        z_next = pwdata[ST_Z_BIT];
        timeout_status_bit_next    = pwdata[ST_TO_BIT];
        power_down_status_bit_next = pwdata[ST_POWER_DOWN_BIT];
      end else if (paddr == ADDR_WORKING) begin
        working_register_next = pwdata[7:0];
      end else if (paddr == ADDR_PC) begin
        pc_next = pwdata[15:0];
      end else if (paddr == ADDR_PC_HIGH_LATCH) begin
        program_counter_high_latch_next = pwdata[7:0];
      end else if (paddr == ADDR_FADDR) begin
        faddr_next = pwdata[7:0];
      end else if (paddr == ADDR_FDATA) begin
        mem_we = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // APB answer: zero wait states
  // ------------------------------------------------------------
  always_comb begin
    pready_next  = setup;
    pslverr_next = setup && (!addr_mapped(paddr) || (pwrite && busy));
    prdata_next  = 32'h0000_0000;
    if (setup && !pwrite) begin
      if (paddr == ADDR_INSTR) begin
        prdata_next = {16'h0000, instr_reg};
      end else if (paddr == ADDR_STATUS) begin
        prdata_next = {27'h0000000, busy, skip_reg, power_down_status_bit_reg,
                       timeout_status_bit_reg, z_reg};
      end else if (paddr == ADDR_WORKING) begin
        prdata_next = {24'h000000, working_register_reg};
      end else if (paddr == ADDR_PC) begin
        prdata_next = {16'h0000, pc_reg};
      end else if (paddr == ADDR_PC_HIGH_LATCH) begin
        prdata_next = {24'h000000, program_counter_high_latch_reg};
      end else if (paddr == ADDR_STACK_TOP) begin
        prdata_next = {16'h0000, stack_top};
      end else if (paddr == ADDR_FADDR) begin
        prdata_next = {24'h000000, faddr_reg};
      end else if (paddr == ADDR_FDATA) begin
        prdata_next = {24'h000000, dmem[faddr_reg]};
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= ST_IDLE;
      ex_reg      <= '0;
      instr_reg   <= 16'h0000;
      call2_reg   <= 1'b0;
      skip_reg    <= 1'b0;
      operand_reg <= RST_BYTE;
      result_reg  <= RST_BYTE;
      working_register_reg <= RST_BYTE;
      pc_reg      <= RST_PC;
      program_counter_high_latch_reg <= RST_BYTE;
      z_reg       <= 1'b0;
      timeout_status_bit_reg    <= RST_TO;
      power_down_status_bit_reg <= RST_POWER_DOWN;
      sp_reg      <= '0;
      faddr_reg   <= RST_BYTE;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      watchdog_clear_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      ex_reg      <= ex_next;
      instr_reg   <= instr_next;
      call2_reg   <= call2_next;
      skip_reg    <= skip_next;
      operand_reg <= operand_next;
      result_reg  <= result_next;
      working_register_reg <= working_register_next;
      pc_reg      <= pc_next;
      program_counter_high_latch_reg <= program_counter_high_latch_next;
      z_reg       <= z_next;
      timeout_status_bit_reg    <= timeout_status_bit_next;
      power_down_status_bit_reg <= power_down_status_bit_next;
      sp_reg      <= sp_next;
      faddr_reg   <= faddr_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      watchdog_clear_reg <= watchdog_clear_next;
    end
  end

  // Storage arrays carry no reset
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      dmem[mem_addr] <= mem_wd;
    end
    if (push) begin
      stack[sp_reg] <= pc_reg + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_phases;
    (state_reg == ST_Q2) ##1 (state_reg == ST_Q3) ##1 (state_reg == ST_Q4);
  endsequence
  sequence s_nop_cycle;
    (state_reg == ST_Q1) ##1 (ex_reg.op == OP_NOP) ##2 (!mem_we && !watchdog_clear_next);
  endsequence

  property p_phase_order;
    (state_reg == ST_Q1) |=> s_phases;
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase order broken");

  property p_bit_test_skip;
    (state_reg == ST_Q3 && ex_reg.op == OP_BIT_TEST_SKIP) |=> (skip_reg == $past(operand_reg[ex_reg.bsel]));
  endproperty
  a_bit_test_skip: assert property (p_bit_test_skip) else $error("bit test skip wrong");

  property p_skip_nop;
    (state_reg == ST_Q1 && skip_reg && !call2_reg) |-> s_nop_cycle;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skipped instruction executed");

  property p_toggle_one_bit;
    (state_reg == ST_Q4 && ex_reg.op == OP_BIT_TOGGLE) |-> mem_we && ($countones(mem_wd ^ operand_reg) == 1)
      && $stable(z_reg);
  endproperty
  a_toggle_one_bit: assert property (p_toggle_one_bit) else $error("toggle changed wrong bits");

  property p_call_pc;
    (state_reg == ST_Q4 && ex_reg.op == OP_CALL) |=> (pc_reg == {$past(pc_reg[15:13]), $past(ex_reg.lit)})
      && (stack_top == $past(pc_reg) + 16'h0001);
  endproperty
  a_call_pc: assert property (p_call_pc) else $error("call target or push wrong");

  property p_call_latch;
    (state_reg == ST_Q4 && ex_reg.op == OP_CALL)
      |=> program_counter_high_latch_reg == {$past(pc_reg[15:13]), $past(ex_reg.lit[12:8])};
  endproperty
  a_call_latch: assert property (p_call_latch) else $error("high latch wrong after call");

  property p_call_two;
    (state_reg == ST_Q4 && ex_reg.op == OP_CALL) |=> (state_reg == ST_Q1) ##1 (ex_reg.op == OP_HOLD)
      ##2 (!mem_we) ##1 ((state_reg == ST_IDLE) && $stable(pc_reg));
  endproperty
  a_call_two: assert property (p_call_two) else $error("call second cycle not idle");

  property p_clear_file;
    (state_reg == ST_Q4 && ex_reg.op == OP_CLEAR_FILE && !ex_reg.dsel) |-> mem_we && (mem_wd == 8'h00)
      ##1 (working_register_reg == 8'h00);
  endproperty
  a_clear_file: assert property (p_clear_file) else $error("clear file missed a target");

  property p_watchdog;
    (state_reg == ST_Q4 && ex_reg.op == OP_WATCHDOG_CLEAR)
      |=> watchdog_clear && timeout_status_bit_reg && power_down_status_bit_reg ##1 !watchdog_clear;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog clear effects missing");

  property p_complement_w;
    (state_reg == ST_Q3 && ex_reg.op == OP_COMPLEMENT_FILE && !ex_reg.dsel)
      |=> ##1 (working_register_reg == ~$past(operand_reg, 2)) && (z_reg == ($past(operand_reg, 2) == 8'hFF));
  endproperty
  a_complement_w: assert property (p_complement_w) else $error("complement to working register wrong");

  property p_compare_equal;
    (state_reg == ST_Q3 && ex_reg.op == OP_COMPARE_EQUAL_SKIP)
      |=> (skip_reg == ($past(operand_reg) == $past(working_register_reg))) ##1
          ($stable(working_register_reg) && $stable(z_reg) && !mem_we);
  endproperty
  a_compare_equal: assert property (p_compare_equal) else $error("compare equal misbehaved");

endmodule

// file: bcce_wdt_model.sv
`timescale 1ns/10ps
module bcce_watchdog_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic watchdog_clear,
  output int        pulses,
  output int        hi_cycles
);
  // ----------------------------------------
  // External watchdog: counts clear requests
  // ----------------------------------------
  logic [7:0] count_reg;
  logic       prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 8'h00;
      prev_reg  <= 1'b0;
      pulses    <= 0;
      hi_cycles <= 0;
    end else begin
      prev_reg  <= watchdog_clear;
      count_reg <= watchdog_clear ? 8'h00 : count_reg + 8'h01;
      if (watchdog_clear && !prev_reg) begin
        pulses <= pulses + 1;
      end
      if (watchdog_clear) begin
        hi_cycles <= hi_cycles + 1;
      end
    end
  end
endmodule

// file: bit_call_clear_compare_exec_tb_top.sv
`timescale 1ns/10ps
module bit_call_clear_compare_exec_tb_top;
  import bcce_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, watchdog_clear;
  logic [7:0]  paddr, fa, v, w;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] seed = 32'h0000002D;
  logic [33:0] notes[$];
  logic [33:0] nt;
  logic [15:0] pc, top_exp;
  logic [12:0] k;
  int          pulses, hi_cycles, failures, checks;

  bcce_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdog_clear(watchdog_clear));
  bcce_watchdog_model wdog (.pclk(pclk), .presetn(presetn), .watchdog_clear(watchdog_clear),
    .pulses(pulses), .hi_cycles(hi_cycles));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic test_done();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic fail(input string m);
    failures++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task automatic cmp_bus(input logic e, input logic [31:0] d, input logic [33:0] n);
    checks++;
    if (e !== n[32]) fail("response code");
    if (n[33] && d !== n[31:0]) fail("read data");
  endtask

  task automatic cmp_watchdog(input int g, input int e);
    checks++;
    if (g !== e) fail("watchdog clear count");
  endtask

  // Request held until pready is seen high; one idle edge avoids double drives
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d, input logic c,
                      input logic [31:0] e, input logic err);
    int n;
    notes.push_back({c, err, e});
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail("bus timeout");
      test_done();
    end
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
    xfer(a, 1'b1, d, 1'b0, 32'h0, err);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    xfer(a, 1'b0, 32'h0, 1'b1, e, err);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      xfer(ADDR_STATUS, 1'b0, 32'h0, 1'b0, 32'h0, 1'b0);
      n++;
    end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 20);
    if (n >= 20) begin
      fail("busy stuck");
      test_done();
    end
  endtask

  task automatic exec(input logic [15:0] ins);
    wr(ADDR_INSTR, {16'h0, ins});
    wait_idle();
    pc++;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) fail("unexpected response");
      else begin
        nt = notes.pop_front();
        cmp_bus(pslverr, prdata, nt);
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(ADDR_STATUS, 32'h6);
    chk(ADDR_PC_HIGH_LATCH, 32'h0);
    chk(8'h20, 32'h0, 1'b1);
    wr(ADDR_STATUS, 32'h0);
    pc = 16'(xs());
    wr(ADDR_PC, {16'h0, pc});
    fa = 8'(xs());
    wr(ADDR_FADDR, {24'h0, fa});
    for (int b = 0; b < 8; b++) begin
      v = 8'(xs());
      wr(ADDR_FDATA, {24'h0, v});
      exec({PAT_BIT_TOGGLE, b[2:0], fa});
      chk(ADDR_FDATA, {24'h0, v ^ (8'h01 << b)});
    end
    chk(ADDR_STATUS, 32'h0);
    chk(ADDR_PC, {16'h0, pc});
    v = 8'(xs());
    v[1:0] = 2'h1;
    for (int b = 0; b < 8; b++) begin
      wr(ADDR_FDATA, {24'h0, v});
      exec({PAT_BIT_TEST_SKIP, b[2:0], fa});
      chk(ADDR_STATUS, {28'h0, v[b], 3'h0});
      exec({PAT_BIT_TOGGLE, 3'h7, fa});
      if (!v[b]) v[7] = ~v[7];
      chk(ADDR_FDATA, {24'h0, v});
    end
    w = 8'(xs());
    wr(ADDR_WORKING, {24'h0, w});
    for (int eq = 1; eq >= 0; eq--) begin
      v = eq ? w : ~w;
      wr(ADDR_FDATA, {24'h0, v});
      exec({PAT_COMPARE_EQUAL_SKIP, fa});
      chk(ADDR_STATUS, {28'h0, eq[0], 3'h0});
      chk(ADDR_WORKING, {24'h0, w});
      exec({PAT_CLEAR_FILE, 1'h1, fa});
      chk(ADDR_FDATA, eq ? {24'h0, v} : 32'h0);
    end
    for (int d = 0; d < 2; d++) begin
      v = d ? 8'hFF : 8'(xs()) & 8'hFE;
      wr(ADDR_FDATA, {24'h0, v});
      wr(ADDR_WORKING, {24'h0, w});
      exec({PAT_COMPLEMENT_FILE, d[0], fa});
      chk(ADDR_WORKING, {24'h0, d ? w : ~v});
      chk(ADDR_FDATA, {24'h0, d ? ~v : v});
      chk(ADDR_STATUS, {31'h0, d[0]});
    end
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_FDATA, {24'h0, 8'(xs()) | 8'h01});
      wr(ADDR_WORKING, {24'h0, w | 8'h01});
      exec({PAT_CLEAR_FILE, s[0], fa});
      chk(ADDR_FDATA, 32'h0);
      chk(ADDR_WORKING, s ? {24'h0, w | 8'h01} : 32'h0);
    end
    exec(PAT_WATCHDOG_CLEAR);
    chk(ADDR_STATUS, 32'h7);
    cmp_watchdog(pulses, 1);
    cmp_watchdog(hi_cycles, 1);
    wr(ADDR_INSTR, {16'h0, PAT_WATCHDOG_CLEAR});
    wr(ADDR_WORKING, 32'h55, 1'b1);
    wait_idle();
    pc++;
    // Refused write leaves the value kept by the last clear with select set
    chk(ADDR_WORKING, {24'h0, w | 8'h01});
    cmp_watchdog(pulses, 2);
    chk(ADDR_PC, {16'h0, pc});
    pc = 16'(xs());
    wr(ADDR_PC, {16'h0, pc});
    k = 13'(xs());
    top_exp = pc + 16'h1;
    exec({PAT_CALL, k});
    // Page bits come from the call's own address, not the incremented one
    pc = top_exp - 16'h1;
    pc = {pc[15:13], k};
    chk(ADDR_STACK_TOP, {16'h0, top_exp});
    chk(ADDR_PC, {16'h0, pc});
    chk(ADDR_PC_HIGH_LATCH, {24'h0, pc[15:13], k[12:8]});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(ADDR_STATUS, 32'h6);
    chk(ADDR_PC, 32'h0);
    test_done();
  end
endmodule
